// [fpo_pkg.sv]
/*
 * fpo_pkg: register offsets, field positions, reset values and timing
 * counts for the fan drive block with its over-temperature override.
 * Assumes a byte-wide register port and a 100 MHz reference clock.
 */
`default_nettype none
package fpo_pkg;
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] FPO_OFS_CFG6      = 8'h10;
	localparam logic [7:0] FPO_OFS_CFG7      = 8'h11;
	localparam logic [7:0] FPO_OFS_STATUS    = 8'h20;
	localparam logic [7:0] FPO_OFS_DUTY0     = 8'h30;
	localparam logic [7:0] FPO_OFS_DUTY1     = 8'h31;
	localparam logic [7:0] FPO_OFS_DUTY2     = 8'h32;
	localparam logic [7:0] FPO_OFS_MAXDUTY   = 8'h38;
	localparam logic [7:0] FPO_OFS_FANMODE   = 8'h5C;
	localparam logic [7:0] FPO_OFS_ACOUST1   = 8'h62;
	localparam logic [7:0] FPO_OFS_CFG3      = 8'h78;
	localparam logic [7:0] FPO_OFS_CFG5      = 8'h7C;
	localparam logic [7:0] FPO_OFS_CFG4      = 8'h7D;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int FPO_BIT_MANUAL_FULL  = 3;  // cfg6
	localparam int FPO_BIT_HYST_OFF     = 0;  // cfg7
	localparam int FPO_BIT_SYNC3        = 4;  // acoustics one
	localparam int FPO_BIT_FULL_SPEED_ON_ALARM        = 2;  // cfg3
	localparam int FPO_BIT_OT_DISABLE   = 2;  // cfg4
	localparam int FPO_BIT_USE_MAX      = 3;  // cfg4
	localparam int FPO_POS_PIN_FUNC     = 0;  // cfg4 <1:0>
	localparam int FPO_POS_CH_EN        = 5;  // cfg5 <7:5>
	localparam int FPO_BIT_MANUAL       = 0;  // fan mode
	localparam int FPO_POS_FREQ         = 1;  // fan mode <3:1>
	localparam logic [1:0] FPO_PIN_FUNC_OT  = 2'h3;
	localparam logic [2:0] FPO_FREQ_HIGH    = 3'h7;
	localparam logic [7:0] FPO_DUTY_FULL    = 8'hFF;
	localparam logic [7:0] FPO_DUTY_OFF     = 8'h00;
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] FPO_RST_ZERO     = 8'h00;
	localparam logic [7:0] FPO_RST_MAXDUTY  = 8'hFF;
	localparam logic [7:0] FPO_RST_CFG5     = 8'hE0;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int          FPO_CLK_MHZ       = 100;
	localparam int          FPO_HIGH_KHZ      = 25;
	localparam int          FPO_LOW_HZ_BASE   = 88;
	localparam logic [15:0] FPO_HIGH_DIV      = 16'(FPO_CLK_MHZ * 1000 / (FPO_HIGH_KHZ * 256));
	localparam logic [15:0] FPO_LOW_DIV_BASE  = 16'(FPO_CLK_MHZ * 1000000 / (FPO_LOW_HZ_BASE * 256 * 64));
	// ************************************************************
	// register image carried as one bundle
	// ************************************************************
	typedef struct packed {
		logic [7:0] cfg6;
		logic [7:0] cfg7;
		logic [7:0] acoust1;
		logic [7:0] cfg3;
		logic [7:0] cfg5;
		logic [7:0] cfg4;
		logic [7:0] fanmode;
		logic [7:0] maxduty;
	} fpo_cfg_type;
endpackage
`default_nettype wire

// [fpo_fan_drive.sv]
/*
 * fpo_fan_drive: three PWM fan drive outputs, over-temperature output
 * with hysteresis, full-speed override and tach-to-PWM timing gates.
 * Assumes limit comparison and the automatic loop sit outside and feed
 * per-channel trip flags and automatic duties on the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module fpo_fan_drive
	import fpo_pkg::*;
#(
	parameter int NCH = 3
) (
	// clock and reset
	input  wire logic            i_ref_clk,
	input  wire logic            i_rst_b,
	// register port
	input  wire logic [7:0]      i_reg_addr,
	input  wire logic [7:0]      i_reg_wdata,
	input  wire logic            i_reg_wr,
	output logic [7:0]           o_reg_rdata,
	// temperature comparison and automatic loop
	input  wire logic [NCH-1:0]  i_temp_above_trip,
	input  wire logic [NCH-1:0]  i_temp_above_limit,
	input  wire logic [NCH*8-1:0] i_auto_duty,
	// pins
	input  wire logic            i_overtemp_signal_in,
	output logic                 o_overtemp_signal_out,
	output logic                 o_overtemp_signal_oe,
	input  wire logic [3:0]      i_speed_in,
	output logic [NCH-1:0]       o_fan_drive,
	// tach timing to the speed counters
	output logic [3:0]           o_speed_sync,
	output logic [3:0]           o_speed_gate
);
	// ************************************************************
	// registers
	// ************************************************************
	fpo_cfg_type      cfg_reg;
	logic [7:0]       duty_reg [NCH];
	logic [NCH-1:0]   hold_reg;
	logic [15:0]      pre_reg;
	logic [7:0]       cnt_reg;
	logic [7:0]       live_reg [NCH];
	logic [4:0]       s1_reg, s2_reg, s3_reg, lvl_reg;
	logic             ovr_reg;

	// decode of the frequency field into a prescale count
	function automatic logic [15:0] fpo_div(input logic [2:0] sel);
		if (sel == FPO_FREQ_HIGH) begin
			return FPO_HIGH_DIV;
		end
		return 16'(FPO_LOW_DIV_BASE << sel);
	endfunction

	logic manual, hyst_off, ot_dis, pin_ok, full_speed_on_alarm_en, alarm_in, period_end;
	logic [NCH-1:0] ch_en, ev_raw, ev_hyst, ev_ch;
	logic           ot_event, fan_ot, high_mode;
	logic [7:0]     ovr_duty;

	assign manual     = cfg_reg.fanmode[FPO_BIT_MANUAL];
	assign high_mode  = cfg_reg.fanmode[FPO_POS_FREQ +: 3] == FPO_FREQ_HIGH;
	assign hyst_off   = cfg_reg.cfg7[FPO_BIT_HYST_OFF];
	assign ot_dis     = cfg_reg.cfg4[FPO_BIT_OT_DISABLE];
	assign pin_ok     = cfg_reg.cfg4[FPO_POS_PIN_FUNC +: 2] == FPO_PIN_FUNC_OT;
	assign full_speed_on_alarm_en   = cfg_reg.cfg3[FPO_BIT_FULL_SPEED_ON_ALARM];
	assign ch_en      = cfg_reg.cfg5[FPO_POS_CH_EN +: NCH];
	assign alarm_in   = ~lvl_reg[4];
	assign period_end = (pre_reg == 16'h0000) && (cnt_reg == 8'hFF);

	// ************************************************************
	// register writes
	// ************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			cfg_reg         <= '0;
			cfg_reg.cfg5    <= FPO_RST_CFG5;
			cfg_reg.maxduty <= FPO_RST_MAXDUTY;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				FPO_OFS_CFG6:    cfg_reg.cfg6    <= i_reg_wdata;
				FPO_OFS_CFG7:    cfg_reg.cfg7    <= i_reg_wdata;
				FPO_OFS_ACOUST1: cfg_reg.acoust1 <= i_reg_wdata;
				FPO_OFS_CFG3:    cfg_reg.cfg3    <= i_reg_wdata;
				FPO_OFS_CFG5:    cfg_reg.cfg5    <= i_reg_wdata;
				FPO_OFS_CFG4:    cfg_reg.cfg4    <= i_reg_wdata;
				FPO_OFS_FANMODE: cfg_reg.fanmode <= i_reg_wdata;
				FPO_OFS_MAXDUTY: cfg_reg.maxduty <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// manual duty registers, one per channel
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_duty
			always_ff @(posedge i_ref_clk) begin
				if (!i_rst_b) begin
					duty_reg[g] <= FPO_RST_ZERO;
				end else if (i_reg_wr && i_reg_addr == 8'(FPO_OFS_DUTY0 + 8'(g))) begin
					duty_reg[g] <= i_reg_wdata;
				end
			end
		end
	endgenerate

	// ************************************************************
	// register reads
	// ************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_reg_rdata <= FPO_RST_ZERO;
		end else begin
			case (i_reg_addr)
				FPO_OFS_CFG6:    o_reg_rdata <= cfg_reg.cfg6;
				FPO_OFS_CFG7:    o_reg_rdata <= cfg_reg.cfg7;
				FPO_OFS_ACOUST1: o_reg_rdata <= cfg_reg.acoust1;
				FPO_OFS_CFG3:    o_reg_rdata <= cfg_reg.cfg3;
				FPO_OFS_CFG5:    o_reg_rdata <= cfg_reg.cfg5;
				FPO_OFS_CFG4:    o_reg_rdata <= cfg_reg.cfg4;
				FPO_OFS_FANMODE: o_reg_rdata <= cfg_reg.fanmode;
				FPO_OFS_MAXDUTY: o_reg_rdata <= cfg_reg.maxduty;
				FPO_OFS_DUTY0:   o_reg_rdata <= duty_reg[0];
				FPO_OFS_DUTY1:   o_reg_rdata <= duty_reg[1];
				FPO_OFS_DUTY2:   o_reg_rdata <= duty_reg[2];
				FPO_OFS_STATUS:  o_reg_rdata <= {4'h0, alarm_in, ovr_reg, fan_ot, o_overtemp_signal_oe};
				default:         o_reg_rdata <= FPO_RST_ZERO;
			endcase
		end
	end

	// ************************************************************
	// pin input synchronisers: four tach inputs and the alarm pin
	// ************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			s1_reg  <= 5'h1F;
			s2_reg  <= 5'h1F;
			s3_reg  <= 5'h1F;
			lvl_reg <= 5'h1F;
		end else begin
			s1_reg  <= {i_overtemp_signal_in, i_speed_in};
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			for (int k = 0; k < 5; k++) begin
				if (s2_reg[k] == s3_reg[k]) begin
					lvl_reg[k] <= s3_reg[k];
				end
			end
		end
	end

	// ************************************************************
	// over-temperature detection with optional hysteresis
	// ************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			hold_reg <= '0;
		end else begin
			for (int k = 0; k < NCH; k++) begin
				if (i_temp_above_trip[k]) begin
					hold_reg[k] <= 1'b1;
				end else if (!i_temp_above_limit[k]) begin
					hold_reg[k] <= 1'b0;
				end
			end
		end
	end

	assign ev_raw   = i_temp_above_trip & ch_en;
	assign ev_hyst  = (hold_reg | i_temp_above_trip) & ch_en;
	assign ev_ch    = hyst_off ? ev_raw : ev_hyst;
	assign ot_event = |ev_ch;

	// pin drive: open drain, driven low while asserted
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_overtemp_signal_oe  <= 1'b0;
			o_overtemp_signal_out <= 1'b0;
		end else begin
			o_overtemp_signal_out <= 1'b0;
			if (!hyst_off) begin
				o_overtemp_signal_oe <= ot_event && pin_ok && !ot_dis;
			end else begin
				o_overtemp_signal_oe <= ot_event && pin_ok;
			end
		end
	end

	// ************************************************************
	// fan override decision
	// ************************************************************
	assign fan_ot   = ot_event && !ot_dis &&
	                  (!manual || cfg_reg.cfg6[FPO_BIT_MANUAL_FULL]);
	assign ovr_duty = cfg_reg.cfg4[FPO_BIT_USE_MAX] ? cfg_reg.maxduty
	                                                : FPO_DUTY_FULL;

	// ************************************************************
	// period timebase shared by all outputs
	// ************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			pre_reg <= '0;
			cnt_reg <= '0;
		end else if (pre_reg == 16'h0000) begin
			pre_reg <= fpo_div(cfg_reg.fanmode[FPO_POS_FREQ +: 3]);
			cnt_reg <= cnt_reg + 8'h01;
		end else begin
			pre_reg <= pre_reg - 16'h0001;
		end
	end

	// override flag taken only at the period boundary
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			ovr_reg <= 1'b0;
		end else if (period_end) begin
			ovr_reg <= fan_ot;
		end
	end

	// ************************************************************
	// per-channel duty selection and PWM output
	// ************************************************************
	generate
		for (g = 0; g < NCH; g++) begin : g_pwm
			logic [7:0] base;
			logic       full_speed_on_alarm;
			assign base  = manual ? duty_reg[g] : i_auto_duty[g*8 +: 8];
			assign full_speed_on_alarm = full_speed_on_alarm_en && alarm_in && (base != FPO_DUTY_OFF);
			always_ff @(posedge i_ref_clk) begin
				if (!i_rst_b) begin
					live_reg[g] <= FPO_DUTY_OFF;
				end else if (period_end) begin
					if (full_speed_on_alarm) begin
						live_reg[g] <= FPO_DUTY_FULL;
					end else if (fan_ot) begin
						live_reg[g] <= ovr_duty;
					end else begin
						live_reg[g] <= base;
					end
				end
			end
			always_ff @(posedge i_ref_clk) begin
				if (!i_rst_b) begin
					o_fan_drive[g] <= 1'b0;
				end else begin
					o_fan_drive[g] <= (live_reg[g] == FPO_DUTY_FULL) ||
					                  (cnt_reg < live_reg[g]);
				end
			end
		end
	endgenerate

	// ************************************************************
	// tach timing gates against the selected drive output
	// ************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_speed_sync <= 4'h0;
			o_speed_gate <= 4'h0;
		end else begin
			o_speed_sync <= lvl_reg[3:0];
			if (high_mode) begin
				o_speed_gate <= 4'hF;
			end else begin
				o_speed_gate[0] <= o_fan_drive[0];
				o_speed_gate[1] <= cfg_reg.acoust1[FPO_BIT_SYNC3] ?
				                   o_fan_drive[2] : o_fan_drive[1];
				o_speed_gate[2] <= o_fan_drive[2];
				o_speed_gate[3] <= o_fan_drive[2];
			end
		end
	end
endmodule
`default_nettype wire

// [fpo_fan_drive_properties.sv]
/* fpo_fan_drive_properties: port checks for the fan drive block.
   Assumes it is bound onto fpo_fan_drive, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module fpo_fan_drive_properties
	import fpo_pkg::*;
#(
	parameter int NCH = 3
) (
	// watched ports
	input wire logic            i_ref_clk,
	input wire logic            i_rst_b,
	input wire logic [7:0]      i_reg_addr,
	input wire logic            i_reg_wr,
	input wire logic [7:0]      o_reg_rdata,
	input wire logic [NCH-1:0]  i_temp_above_trip,
	input wire logic            o_overtemp_signal_out,
	input wire logic            o_overtemp_signal_oe,
	input wire logic [NCH-1:0]  o_fan_drive,
	input wire logic [3:0]      o_speed_gate
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	// pin data is always the low level
	property p_out_low; o_overtemp_signal_out == 1'b0; endproperty
	a_out_low: assert property (p_out_low) else $error("alarm pin data not low");
	// reset clears the drive outputs
	property p_rst; disable iff (1'b0) !i_rst_b |=> (o_fan_drive == '0) && !o_overtemp_signal_oe; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	// pin pulled only after a trip
	property p_rise; $rose(o_overtemp_signal_oe) |-> $past(|i_temp_above_trip); endproperty
	a_rise: assert property (p_rise) else $error("alarm pin pulled without trip");
	// release while every channel trips only one or two cycles after a register write
	property p_fall; $fell(o_overtemp_signal_oe) |-> $past(i_reg_wr) || $past(i_reg_wr, 2) || !$past(&i_temp_above_trip); endproperty
	a_fall: assert property (p_fall) else $error("alarm pin released during trip");
	// gates 0 and 2 follow their own drive, gate 3 drive three, gate 1 drive two or three, or stay high
	property p_gate0; !o_speed_gate[0] |-> !$past(o_fan_drive[0]); endproperty
	a_gate0: assert property (p_gate0) else $error("gate 0 off its drive");
	property p_gate2; !o_speed_gate[2] |-> !$past(o_fan_drive[2]); endproperty
	a_gate2: assert property (p_gate2) else $error("gate 2 off drive three");
	property p_gate3; !o_speed_gate[3] |-> !$past(o_fan_drive[2]); endproperty
	a_gate3: assert property (p_gate3) else $error("gate 3 off drive three");
	property p_gate1; !o_speed_gate[1] |-> !$past(o_fan_drive[1]) || !$past(o_fan_drive[2]); endproperty
	a_gate1: assert property (p_gate1) else $error("gate 1 off both drives");
	// unmapped offset reads zero
	property p_unmapped; i_reg_addr == 8'h00 |=> o_reg_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind fpo_fan_drive fpo_fan_drive_properties #(.NCH(NCH)) u_props (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
	.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .o_reg_rdata(o_reg_rdata), .i_temp_above_trip(i_temp_above_trip),
	.o_overtemp_signal_out(o_overtemp_signal_out), .o_overtemp_signal_oe(o_overtemp_signal_oe),
	.o_fan_drive(o_fan_drive), .o_speed_gate(o_speed_gate));
`default_nettype wire

// [fpo_fan_partner.sv]
/* fpo_fan_partner: four fans with open-drain tach and the alarm line.
   Assumes the bench pulls the alarm through i_alarm_pull. */
`timescale 1ns/1ps
`default_nettype none
module fpo_fan_partner (
	// drive side
	input wire logic        i_ref_clk,
	input wire logic [2:0]  i_fan_drive,
	input wire logic        i_oe,
	input wire logic        i_alarm_pull,
	// lines back
	output logic [3:0]      o_tach,
	output logic            o_alarm_pin
);
	logic [15:0] cnt_reg = 16'h0000;
	logic [3:0]  run;
	// fourth fan shares drive three
	assign run = {i_fan_drive[2], i_fan_drive};
	// rotation time base
	always @(posedge i_ref_clk) begin
		cnt_reg <= cnt_reg + 16'h0001;
	end
	// stopped fan leaves tach on its pull-up
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			o_tach[k] = run[k] ? cnt_reg[k + 4] : 1'b1;
		end
	end
	// wired low by either party, else pulled up
	assign o_alarm_pin = !((i_oe === 1'b1) || i_alarm_pull);
endmodule
`default_nettype wire

// [fpo_fan_drive_tb.sv]
/* fpo_fan_drive_tb: self-checking bench for the fan drive block.
   Assumes fpo_fan_partner on the far side and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module fpo_fan_drive_tb import fpo_pkg::*; ;
	localparam int PER  = 256 * (int'(FPO_HIGH_DIV) + 1);
	localparam int LPER = 256 * (int'(FPO_LOW_DIV_BASE) + 1);
	logic        i_ref_clk = 1'b0;
	logic        i_rst_b   = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic [2:0]  trip = 3'h0;
	logic [2:0]  lim = 3'h0;
	logic [23:0] auto_d = 24'h000000;
	logic        pull = 1'b0;
	logic        look = 1'b0;
	logic        look_q = 1'b0;
	logic [7:0]  rdata, v, d;
	logic        oe, out, pin;
	logic [2:0]  drive;
	logic [3:0]  tach, sync, gate;
	logic [15:0] meas;
	logic [17:0] n;
	logic [17:0] notes[$];
	logic [7:0]  ofs[6] = '{FPO_OFS_CFG6, FPO_OFS_CFG7, FPO_OFS_ACOUST1, FPO_OFS_CFG3, FPO_OFS_CFG4, FPO_OFS_DUTY1};
	int          err_count = 0;
	int          comparisons = 0;
	int          seed = 32'h869d;
	int          cyc = 0;
	// clock
	initial begin
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	fpo_fan_drive uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .o_reg_rdata(rdata), .i_temp_above_trip(trip), .i_temp_above_limit(lim),
		.i_auto_duty(auto_d), .i_overtemp_signal_in(pin), .o_overtemp_signal_out(out),
		.o_overtemp_signal_oe(oe), .i_speed_in(tach), .o_fan_drive(drive), .o_speed_sync(sync),
		.o_speed_gate(gate));
	fpo_fan_partner fans (.i_ref_clk(i_ref_clk), .i_fan_drive(drive), .i_oe(oe), .i_alarm_pull(pull),
		.o_tach(tach), .o_alarm_pin(pin));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// note an expectation for the watcher
	task automatic note(input logic [1:0] k, input logic [15:0] e);
		notes.push_back({k, e});
		look = 1'b1;
		@(negedge i_ref_clk);
		look = 1'b0;
		@(negedge i_ref_clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] dat);
		addr = a;
		wdata = dat;
		wr = 1'b1;
		@(negedge i_ref_clk);
		wr = 1'b0;
		@(negedge i_ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		note(2'h0, {8'h00, e});
	endtask
	task automatic tset(input logic [2:0] t, input logic [2:0] l);
		trip = t;
		lim = l;
		repeat (3) @(negedge i_ref_clk);
	endtask
	// count high time of drive one over a period
	task automatic duty(input logic [15:0] e);
		int hi;
		hi = 0;
		// margin covers a leftover low-frequency prescale after a mode switch
		repeat (PER + 100) @(negedge i_ref_clk);
		repeat (PER) begin
			@(negedge i_ref_clk);
			hi += drive[0];
		end
		meas = 16'(hi / (int'(FPO_HIGH_DIV) + 1));
		note(2'h3, e);
	endtask
	// watcher takes the oldest note two edges on
	always @(posedge i_ref_clk) begin
		if (look_q) begin
			n = notes.pop_front();
			case (n[17:16])
				2'h0: chk({8'h00, rdata}, n[15:0]);
				2'h1: chk({15'h0000, oe}, n[15:0]);
				2'h2: chk({12'h000, gate}, n[15:0]);
				default: chk(meas, n[15:0]);
			endcase
		end
		look_q <= look;
	end
	// hang guard
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 95000) begin
			err_count++;
			final_report();
		end
	end
	// main sequence
	initial begin
		repeat (8) @(negedge i_ref_clk);
		i_rst_b = 1'b1;
		auto_d = 24'($random(seed));
		rd(FPO_OFS_CFG5, FPO_RST_CFG5);
		rd(FPO_OFS_MAXDUTY, FPO_RST_MAXDUTY);
		rd(8'h00, 8'h00);
		foreach (ofs[i]) begin
			v = 8'($random(seed));
			wreg(ofs[i], v);
			rd(ofs[i], v);
			wreg(ofs[i], 8'h00);
		end
		$display("test registers done");
		wreg(FPO_OFS_CFG4, {6'h00, FPO_PIN_FUNC_OT});
		for (int k = 0; k < 3; k++) begin
			wreg(FPO_OFS_CFG5, 8'(1 << (k + FPO_POS_CH_EN)));
			for (int j = 0; j < 3; j++) begin
				tset(3'(1 << j), 3'(1 << j));
				note(2'h1, 16'(j == k));
				tset(3'h0, 3'h0);
			end
		end
		wreg(FPO_OFS_CFG5, FPO_RST_CFG5);
		tset(3'h2, 3'h2);
		note(2'h1, 16'h0001);
		tset(3'h0, 3'h2);
		note(2'h1, 16'h0001);
		tset(3'h0, 3'h0);
		note(2'h1, 16'h0000);
		wreg(FPO_OFS_CFG4, {5'h00, 1'b1, FPO_PIN_FUNC_OT});
		tset(3'h4, 3'h4);
		note(2'h1, 16'h0000);
		wreg(FPO_OFS_CFG7, 8'h01);
		note(2'h1, 16'h0001);
		tset(3'h0, 3'h4);
		note(2'h1, 16'h0000);
		tset(3'h0, 3'h0);
		wreg(FPO_OFS_CFG7, 8'h00);
		$display("test alarm pin done");
		d = (8'($random(seed)) & 8'h7F) | 8'h01;
		wreg(FPO_OFS_FANMODE, {4'h0, FPO_FREQ_HIGH, 1'b1});
		wreg(FPO_OFS_DUTY0, d);
		duty({8'h00, d});
		wreg(FPO_OFS_CFG4, {6'h00, FPO_PIN_FUNC_OT});
		tset(3'h1, 3'h1);
		duty({8'h00, d});
		wreg(FPO_OFS_CFG6, 8'h08);
		duty(16'h0100);
		wreg(FPO_OFS_MAXDUTY, 8'hC0);
		wreg(FPO_OFS_CFG4, {4'h0, 1'b1, 1'b0, FPO_PIN_FUNC_OT});
		duty(16'h00C0);
		wreg(FPO_OFS_CFG4, {4'h0, 1'b1, 1'b1, FPO_PIN_FUNC_OT});
		duty({8'h00, d});
		tset(3'h0, 3'h0);
		wreg(FPO_OFS_CFG6, 8'h00);
		wreg(FPO_OFS_CFG3, 8'h04);
		pull = 1'b1;
		duty(16'h0100);
		wreg(FPO_OFS_DUTY0, FPO_DUTY_OFF);
		duty(16'h0000);
		pull = 1'b0;
		$display("test fan duty done");
		// stopped fans leave every tach line on its pull-up
		meas = {12'h000, sync};
		note(2'h3, 16'h000F);
		note(2'h2, 16'h000F);
		wreg(FPO_OFS_DUTY1, FPO_DUTY_FULL);
		wreg(FPO_OFS_FANMODE, 8'h01);
		repeat (LPER + 300) @(negedge i_ref_clk);
		note(2'h2, 16'h0002);
		wreg(FPO_OFS_ACOUST1, 8'h10);
		note(2'h2, 16'h0000);
		$display("test speed gates done");
		final_report();
	end
endmodule
`default_nettype wire
